/* rtl/rsc_pkg.sv */
// Constants, register map and field positions of the reset source combiner.
// Assumes an 8-bit register port and a single 125 MHz system clock.
// Function
// RL1 - Reset while power-on or pin reset active
// RL2 - Warm-up starts when later source releases
// RL3 - Hold core idle until warm-up completes
// RL4 - Shared pin powers up as reset input
// RL5 - Slow supply: board holds pin low
// RL6 - Pin low 5 us resets; rise starts warm-up
// RL7 - Voltage detection causes internal factor reset
// RL8 - Watchdog overflow causes internal factor reset
// RL9 - Clock deadlock setting causes internal reset
// RL10 - Load and latch trim data during warm-up
// RL11 - Corrupted latched trim data causes reset
// RL12 - Abnormal trim load sets trim fault flag
// RL13 - Software retriggers reset on trim fault
// RL14 - Flash access in standby causes reset
// RL15 - Record internal reset cause, not power-on
// RL16 - Only pin or power-on clears cause; the armed key 0x71 also clears it here
// RL17 - Arm plus key 0x71 clears cause record
// RL18 - Software writes arm and key consecutively
// RL19 - Disable bit plus key 0xB2 frees pin
// RL20 - Cleared bit plus key restores reset pin
// RL21 - Board holds pin high before conversion
// RL22 - Switch pin function only while high
// RL23 - Warm-up counts clock; reset restarts it
// RL24 - Core starts from top-of-memory reset vector
// RL25 - Sources assert at once, release synchronised
package rsc_pkg;
	// Register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [3:0] OFS_CAUSE = 4'h0;
	localparam logic [3:0] OFS_SYSCFG = 4'h1;
	localparam logic [3:0] OFS_KEY = 4'h2;
	localparam logic [3:0] OFS_TRIM = 4'h3;
	// Cause register field positions
	localparam int BIT_VDET = 0;
	localparam int BIT_WDT = 1;
	localparam int BIT_CLK = 2;
	localparam int BIT_TRIM = 3;
	localparam int BIT_FLASH = 4;
	localparam int BIT_TFAULT = 5;
	localparam int BIT_ARM = 7;
	localparam int NFACT = 5;
	// System config field position
	localparam int BIT_PINDIS = 0;
	// Protection keys
	localparam logic [7:0] KEY_CAUSE_CLR = 8'h71;
	localparam logic [7:0] KEY_PIN_SW = 8'hb2;
	// Reset values
	localparam logic [7:0] CAUSE_RST = 8'h00;
	localparam logic [7:0] TRIM_RST = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'hfffe;
	// Warm-up length in clock cycles
	localparam int WARMUP_CYCLES = 2048;
	localparam int WCNT_W = 12;
	localparam logic [11:0] WARMUP_LAST = 12'(WARMUP_CYCLES - 1);
endpackage

/* rtl/rsc_reset_combiner.sv */
// Reset source combiner: merges power-on, pin and internal factor resets,
// runs the warm-up, latches trim data and keeps the cause record.
// Assumes all inputs synchronous to clk_sys_in and one-cycle register strobes.
`timescale 1ns/10ps
module rsc_reset_combiner (
	// Clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// Reset sources
	input wire logic por_active_in,
	input wire logic pin_level_in,
	// Internal factor sources
	input wire logic vdet_hit_in,
	input wire logic wdt_ovf_in,
	input wire logic hf_osc_en_in,
	input wire logic lf_osc_en_in,
	input wire logic sysck_low_sel_in,
	input wire logic flash_stby_acc_in,
	// Trim storage
	input wire logic [7:0] trim_nv_data_in,
	input wire logic trim_nv_check_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// System side
	output logic sys_rst_n_out,
	output logic core_run_out,
	output logic core_start_out,
	output logic [15:0] start_addr_out,
	output logic [7:0] trim_latched_out,
	output logic pin_reset_en_out
);
	// Reset release synchroniser, first stage read only by second
	logic rel_s1_q;
	logic rel_s2_q;
	// Warm-up state
	typedef enum logic [1:0] {RSC_HOLD, RSC_WARM, RSC_RUN} rsc_state_e;
	rsc_state_e state_q;
	logic [11:0] wcnt_q;
	// Run flag kept beside the state so the output comes from a flop
	logic run_q;
	// Register state
	logic [7:0] cause_q;
	logic pin_dis_q;
	logic pin_en_q;
	logic [7:0] trim_q;
	logic [7:0] trim_dup_q;
	logic [7:0] rdata_q;
	logic start_q;
	logic [15:0] vec_q;
	// Combinational terms
	logic pin_rst;
	logic ext_rst;
	logic [4:0] factors;
	logic any_rst;
	logic wr_key;
	logic trim_load;
	logic trim_bad;

	// Register address decode, shared by read and write paths
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	// Pin only counts as reset while its reset function is enabled
	assign pin_rst = pin_en_q & ~pin_level_in; // RL6
	assign ext_rst = por_active_in | pin_rst; // RL1
	// Deadlock when the selected system clock source is switched off
	assign factors[rsc_pkg::BIT_VDET] = vdet_hit_in; // RL7
	assign factors[rsc_pkg::BIT_WDT] = wdt_ovf_in; // RL8
	assign factors[rsc_pkg::BIT_CLK] = sysck_low_sel_in ? ~lf_osc_en_in : ~hf_osc_en_in; // RL9
	assign factors[rsc_pkg::BIT_TRIM] = (state_q == RSC_RUN) && (trim_q != trim_dup_q); // RL11
	assign factors[rsc_pkg::BIT_FLASH] = flash_stby_acc_in; // RL14
	assign any_rst = ext_rst | (|factors);
	assign wr_key = reg_wr_in && hit(reg_addr_in, rsc_pkg::OFS_KEY);
	assign trim_load = (state_q == RSC_WARM) && (wcnt_q == '0);
	assign trim_bad = (^trim_nv_data_in) != trim_nv_check_in;

	// Release synchroniser: any source drops both stages at once,
	// release walks through two flops so warm-up starts cleanly
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			rel_s1_q <= 1'b0;
			rel_s2_q <= 1'b0;
		end else if (ce_in) begin
			if (any_rst) begin // RL25
				rel_s1_q <= 1'b0;
				rel_s2_q <= 1'b0;
			end else begin // RL2
				rel_s1_q <= 1'b1;
				rel_s2_q <= rel_s1_q;
			end
		end
	end

	// Warm-up sequencer; a new reset in any state returns to hold
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			state_q <= RSC_HOLD;
			wcnt_q <= '0;
			run_q <= 1'b0;
		end else if (ce_in) begin
			if (!rel_s2_q) begin // RL23
				state_q <= RSC_HOLD;
				wcnt_q <= '0;
				run_q <= 1'b0; // RL3
			end else begin
				unique case (state_q)
					RSC_HOLD: begin
						state_q <= RSC_WARM; // RL2
					end
					RSC_WARM: begin
						// Counting the system clock stands in for the oscillator warm-up
						if (wcnt_q == rsc_pkg::WARMUP_LAST) begin // RL23
							state_q <= RSC_RUN;
							run_q <= 1'b1; // RL3
						end else begin
							wcnt_q <= wcnt_q + 12'h001;
						end
					end
					RSC_RUN: begin
						state_q <= RSC_RUN;
					end
				endcase
			end
		end
	end

	// Core outputs: start strobe only after warm-up ends, vector fixed
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			start_q <= 1'b0;
			vec_q <= rsc_pkg::RESET_VECTOR;
		end else if (ce_in) begin
			// One-cycle start strobe on the last warm-up count
			start_q <= rel_s2_q && (state_q == RSC_WARM) && (wcnt_q == rsc_pkg::WARMUP_LAST); // RL3
			vec_q <= rsc_pkg::RESET_VECTOR; // RL24
		end
	end

	// Trim latch: loaded once per warm-up, duplicated to spot upsets later
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			trim_q <= rsc_pkg::TRIM_RST;
			trim_dup_q <= rsc_pkg::TRIM_RST;
		end else if (ce_in && trim_load) begin // RL10
			trim_q <= trim_nv_data_in;
			trim_dup_q <= trim_nv_data_in;
		end
	end

	// Cause record: pin or power-on clears it, factor resets only add to it;
	// an event in the clearing cycle is lost since the clear branch skips the sets
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			cause_q <= rsc_pkg::CAUSE_RST;
		end else if (ce_in) begin
			if (ext_rst) begin // RL16
				cause_q <= rsc_pkg::CAUSE_RST;
			end else begin
				// Arm bit write by software, status bits are read-only
				if (reg_wr_in && hit(reg_addr_in, rsc_pkg::OFS_CAUSE)) begin
					cause_q[rsc_pkg::BIT_ARM] <= reg_wdata_in[rsc_pkg::BIT_ARM];
				end
				// Armed key clears record and drops the arm bit itself
				if (wr_key && reg_wdata_in == rsc_pkg::KEY_CAUSE_CLR && cause_q[rsc_pkg::BIT_ARM]) begin // RL17
					cause_q <= {3'h0, 5'(factors)};
				end else begin
					cause_q[4:0] <= cause_q[4:0] | factors; // RL15
				end
				// Fault flag follows each load result
				if (trim_load) begin // RL12
					cause_q[rsc_pkg::BIT_TFAULT] <= trim_bad;
				end
			end
		end
	end

	// Pin function: the disable bit only takes effect with the key
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			pin_dis_q <= 1'b0;
			pin_en_q <= 1'b1; // RL4
		end else if (ce_in) begin
			if (por_active_in) begin // RL4
				pin_dis_q <= 1'b0;
				pin_en_q <= 1'b1;
			end else begin
				if (reg_wr_in && hit(reg_addr_in, rsc_pkg::OFS_SYSCFG)) begin
					pin_dis_q <= reg_wdata_in[rsc_pkg::BIT_PINDIS];
				end
				// Switching while the pin is low can itself reset the chip
				if (wr_key && reg_wdata_in == rsc_pkg::KEY_PIN_SW) begin // RL19 RL20
					pin_en_q <= ~pin_dis_q;
				end
			end
		end
	end

	// Read data stands for exactly the cycle after the read strobe
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			rdata_q <= 8'h00;
		end else if (ce_in) begin
			rdata_q <= 8'h00;
			if (reg_rd_in) begin
				if (hit(reg_addr_in, rsc_pkg::OFS_CAUSE)) begin
					rdata_q <= cause_q;
				end else if (hit(reg_addr_in, rsc_pkg::OFS_SYSCFG)) begin
					rdata_q <= {7'h00, pin_dis_q};
				end else if (hit(reg_addr_in, rsc_pkg::OFS_TRIM)) begin
					rdata_q <= trim_q;
				end
			end
		end
	end

	// Output mapping, all from flops
	assign reg_rdata_out = rdata_q;
	assign sys_rst_n_out = rel_s2_q;
	assign core_run_out = run_q;
	assign core_start_out = start_q;
	assign start_addr_out = vec_q;
	assign trim_latched_out = trim_q;
	assign pin_reset_en_out = pin_en_q;

	// Checks
	sequence s_pin_rst;
		ce_in && pin_en_q && !pin_level_in;
	endsequence
	sequence s_warm_done;
		ce_in && state_q == RSC_WARM && wcnt_q == rsc_pkg::WARMUP_LAST && rel_s2_q;
	endsequence

	AST_POR_RESETS: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL1
		ce_in && por_active_in |=> !sys_rst_n_out) else $error("power-on did not reset");
	AST_PIN_RESETS: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL6
		s_pin_rst |=> !sys_rst_n_out ##1 !core_run_out) else $error("pin low did not reset");
	AST_RELEASE_TWO: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL25
		ce_in && any_rst ##1 (ce_in && !any_rst) [*2] |=> sys_rst_n_out) else $error("release not two stages");
	AST_IDLE_WARM: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL3
		$rose(core_run_out) |-> $past(state_q) == RSC_WARM && $past(wcnt_q) == rsc_pkg::WARMUP_LAST)
		else $error("core ran before warm-up end");
	AST_START_PULSE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL24
		s_warm_done |=> core_start_out && core_run_out && start_addr_out == 16'hfffe) else $error("bad start");
	AST_WARM_RESTART: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL23
		ce_in && state_q == RSC_WARM && any_rst |=> ##1 wcnt_q == '0 && state_q == RSC_HOLD)
		else $error("warm-up not restarted");
	AST_CAUSE_WDT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL8
		ce_in && wdt_ovf_in && !ext_rst |=> cause_q[rsc_pkg::BIT_WDT] && !sys_rst_n_out)
		else $error("watchdog cause lost");
	AST_CAUSE_KEEP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL16
		ce_in && !ext_rst && !wr_key |=> (cause_q[4:0] & $past(cause_q[4:0])) == $past(cause_q[4:0]))
		else $error("cause dropped without clear");
	AST_KEY_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL17
		ce_in && !ext_rst && wr_key && reg_wdata_in == 8'h71 && cause_q[7] && factors == '0
		|=> cause_q == 8'h00) else $error("key did not clear cause");
	AST_PIN_SWITCH: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL19
		ce_in && !por_active_in && wr_key && reg_wdata_in == 8'hb2 |=> pin_reset_en_out == !$past(pin_dis_q))
		else $error("pin function not switched");
	AST_TRIM_FLAG: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL12
		ce_in && trim_load && !ext_rst |=> cause_q[5] == $past(trim_bad)) else $error("trim flag wrong");

	// Release walk: reset seen low, then high at the next edge
	sequence s_release;
		ce_in && !sys_rst_n_out ##1 ce_in && sys_rst_n_out;
	endsequence

	// Warm-up begins with a cleared counter right after release
	AST_WARM_BEGIN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL2
		s_release |=> state_q == RSC_WARM && wcnt_q == '0) else $error("warm-up did not begin");
	// Core stays idle while reset is held; one edge of slack for the flop
	AST_CORE_IDLE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL3
		ce_in && !sys_rst_n_out ##1 !sys_rst_n_out |-> !core_run_out) else $error("core ran under reset");
	// Power-on brings the shared pin back to its reset function
	AST_POR_PIN_EN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL4
		ce_in && por_active_in |=> pin_reset_en_out && !pin_dis_q) else $error("pin not reset input");
	// Each internal factor is recorded and resets the system
	AST_CAUSE_VDET: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL7
		ce_in && vdet_hit_in && !ext_rst |=> cause_q[rsc_pkg::BIT_VDET] && !sys_rst_n_out)
		else $error("voltage cause lost");
	AST_CAUSE_CLK: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL9
		ce_in && (sysck_low_sel_in ? !lf_osc_en_in : !hf_osc_en_in) && !ext_rst
		|=> cause_q[rsc_pkg::BIT_CLK] && !sys_rst_n_out) else $error("clock cause lost");
	AST_CAUSE_FLASH: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL14
		ce_in && flash_stby_acc_in && !ext_rst |=> cause_q[rsc_pkg::BIT_FLASH] && !sys_rst_n_out)
		else $error("flash cause lost");
	// Pin or power-on wipes the whole record
	AST_EXT_CLEARS: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL16
		ce_in && ext_rst |=> cause_q == rsc_pkg::CAUSE_RST) else $error("record not cleared");
	// Trim word is latched at the start of every warm-up
	AST_TRIM_LOAD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL10
		ce_in && trim_load |=> trim_latched_out == $past(trim_nv_data_in)) else $error("trim not latched");
	// In port mode a low pin leaves the system running
	AST_PORT_NO_RST: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RL19
		ce_in && !pin_en_q && !pin_level_in && !por_active_in && factors == '0 && sys_rst_n_out
		|=> sys_rst_n_out) else $error("port level caused reset");
endmodule

/* verif/rsc_board_model.sv */
// Board-side model: power supervisor and the driver of the shared reset pin.
// Assumes the bench calls its tasks; outputs change just after a rising edge.
`timescale 1ns/10ps
module rsc_board_model #(
	parameter int HOLD_CYC = 625 // Low time of the pin, 5 us at 8 ns
) (
	// Clock
	input wire logic clk_in,
	// Board outputs
	output logic por_out,
	output logic pin_out
);
	// Supply below release level and pin held low at power-up
	initial begin
		por_out = 1'b1;
		pin_out = 1'b0;
	end
	// Supply reaches its operating range
	task automatic release_por();
		@(posedge clk_in);
		por_out <= 1'b0;
	endtask
	// Keep the pin low past a stable supply, then pull it high
	task automatic release_pin();
		repeat (HOLD_CYC) @(posedge clk_in);
		pin_out <= 1'b1;
	endtask
	// Full pin reset with a stable supply; only ever started from a high pin
	task automatic pin_reset();
		@(posedge clk_in);
		pin_out <= 1'b0;
		release_pin();
	endtask
endmodule

/* verif/tb.sv */
// Self-checking bench of the reset source combiner with a board model.
// Assumes the package constants and a 125 MHz clock; read results checked by a queue.
`timescale 1ns/10ps
module tb;
	logic clk, nrst, rd, wr, hf_en, lf_en, lo_sel, vdet, wdt, flash, trim_ck;
	logic [3:0] addr;
	logic [7:0] wdata, trim_d, exp_cause;
	logic [7:0] rdata, trim_l;
	logic [15:0] start_a;
	logic srst_n, run, start, pin_en, por, pin, pend;
	logic [7:0] exp_q[$];
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	// Board model drives supply and pin
	rsc_board_model board_i (.clk_in(clk), .por_out(por), .pin_out(pin));
	rsc_reset_combiner rsc_reset_combiner_i (.clk_sys_in(clk), .nrst_in(nrst), .ce_in(1'b1),
		.por_active_in(por), .pin_level_in(pin), .vdet_hit_in(vdet), .wdt_ovf_in(wdt),
		.hf_osc_en_in(hf_en), .lf_osc_en_in(lf_en), .sysck_low_sel_in(lo_sel),
		.flash_stby_acc_in(flash), .trim_nv_data_in(trim_d), .trim_nv_check_in(trim_ck),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .sys_rst_n_out(srst_n), .core_run_out(run),
		.core_start_out(start), .start_addr_out(start_a), .trim_latched_out(trim_l),
		.pin_reset_en_out(pin_en));
	// 8 ns clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Compare and count
	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, well above eight warm-ups
	always @(posedge clk) begin
		cyc++;
		if (cyc > 40000) begin
			n_errors++;
			wrap_up();
		end
	end
	// Read data stand one cycle after the strobe
	always @(negedge clk) begin
		if (pend) begin
			check("rdata", rdata, exp_q.pop_front());
		end
		pend = rd;
	end
	task automatic wr_reg(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [3:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Wait for release, then time the warm-up up to the start pulse
	task automatic wait_run();
		int n;
		n = 0;
		while (srst_n !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (run !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		check("warmup", n >= rsc_pkg::WARMUP_CYCLES && n < rsc_pkg::WARMUP_CYCLES + 8, 1);
		check("start", start, 1);
		check("vector", start_a, rsc_pkg::RESET_VECTOR);
	endtask
	// One-cycle internal factor request, then the reset must follow
	task automatic factor(int b);
		@(posedge clk);
		vdet <= (b == rsc_pkg::BIT_VDET);
		wdt <= (b == rsc_pkg::BIT_WDT);
		hf_en <= !(b == rsc_pkg::BIT_CLK && !lo_sel);
		lf_en <= !(b == rsc_pkg::BIT_CLK && lo_sel);
		flash <= (b == rsc_pkg::BIT_FLASH);
		@(posedge clk);
		{vdet, wdt, flash} <= 3'h0;
		{hf_en, lf_en} <= 2'h3;
		// Release follows two edges later, so look in the first cycle
		@(negedge clk);
		check("factor_rst", srst_n, 0);
	endtask
	// Main sequence
	initial begin
		{nrst, rd, wr, vdet, wdt, flash, lo_sel} = 7'h0;
		{hf_en, lf_en} = 2'h3;
		addr = 4'h0;
		wdata = 8'h00;
		void'($urandom(32'h4922));
		trim_d = 8'($urandom());
		trim_ck = ^trim_d;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		// Slow supply: pin released after power-on reset
		board_i.release_por();
		repeat (50) @(negedge clk);
		check("pin_hold", srst_n, 0);
		board_i.release_pin();
		wait_run();
		check("pin_en", pin_en, 1);
		check("trim", trim_l, trim_d);
		rd_reg(rsc_pkg::OFS_CAUSE, 8'h00);
		rd_reg(rsc_pkg::OFS_TRIM, trim_d);
		rd_reg(rsc_pkg::OFS_KEY, 8'h00);
		rd_reg(4'hf, 8'h00);
		// Bad trim word on the next load
		trim_ck <= ~^trim_d;
		factor(rsc_pkg::BIT_WDT);
		wait_run();
		rd_reg(rsc_pkg::OFS_CAUSE, 8'h22);
		trim_ck <= ^trim_d;
		exp_cause = 8'h02;
		// Each factor is recorded and kept; a repeat restarts warm-up
		for (int i = 0; i < 3; i++) begin
			factor(i == 0 ? rsc_pkg::BIT_VDET : (i == 1 ? rsc_pkg::BIT_CLK : rsc_pkg::BIT_FLASH));
			if (i == 2) begin
				repeat (1000) @(posedge clk);
				factor(rsc_pkg::BIT_FLASH);
			end
			exp_cause[i == 0 ? 0 : (i == 1 ? 2 : 4)] = 1'b1;
			wait_run();
			rd_reg(rsc_pkg::OFS_CAUSE, exp_cause);
		end
		// Wrong key keeps the record, right key clears it and the arm bit
		wr_reg(rsc_pkg::OFS_CAUSE, 8'h80);
		wr_reg(rsc_pkg::OFS_KEY, 8'h55);
		rd_reg(rsc_pkg::OFS_CAUSE, exp_cause | 8'h80);
		wr_reg(rsc_pkg::OFS_CAUSE, 8'h80);
		wr_reg(rsc_pkg::OFS_KEY, rsc_pkg::KEY_CAUSE_CLR);
		rd_reg(rsc_pkg::OFS_CAUSE, 8'h00);
		// Pin to port use while it is high; a low level then resets nothing
		wr_reg(rsc_pkg::OFS_SYSCFG, 8'h01);
		@(negedge clk);
		check("pin_nokey", pin_en, 1);
		wr_reg(rsc_pkg::OFS_KEY, rsc_pkg::KEY_PIN_SW);
		@(negedge clk);
		check("pin_port", pin_en, 0);
		board_i.pin_reset();
		@(negedge clk);
		check("port_low", srst_n, 1);
		wr_reg(rsc_pkg::OFS_SYSCFG, 8'h00);
		wr_reg(rsc_pkg::OFS_KEY, rsc_pkg::KEY_PIN_SW);
		@(negedge clk);
		check("pin_back", pin_en, 1);
		// Watchdog factor after the key clear is recorded on its own
		factor(rsc_pkg::BIT_WDT);
		wait_run();
		rd_reg(rsc_pkg::OFS_CAUSE, 8'h02);
		// Deadlock through the low-frequency source as well
		lo_sel <= 1'b1;
		factor(rsc_pkg::BIT_CLK);
		wait_run();
		rd_reg(rsc_pkg::OFS_CAUSE, 8'h06);
		fork
			board_i.pin_reset();
			begin
				repeat (20) @(negedge clk);
				check("pin_rst", srst_n, 0);
			end
		join
		wait_run();
		rd_reg(rsc_pkg::OFS_CAUSE, 8'h00);
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule
